// >>> hdl/exb_pkg.sv
// Constants and types shared by the expansion bus pin block
`default_nettype none
package exb_pkg;
  typedef enum logic [1:0] {
    exb_mode_fifo,
    exb_mode_async,
    exb_mode_host_dev,
    exb_mode_host_ext
  } exb_mode_type;
  localparam int EXB_DATA_W = 32;
  localparam int EXB_PIN_W = 4;
  localparam int EXB_CS_W = 2;
  localparam int EXB_CNT_W = 4;
  localparam int EXB_FIFO_DEPTH = 16;
  localparam logic [1:0] EXB_FIFO_CS = 2'h3;
  // Command word layout
  localparam int EXB_CMD_DATA_LSB = 0;
  localparam int EXB_CMD_ADDR_LSB = 32;
  localparam int EXB_CMD_BE_LSB = 36;
  localparam int EXB_CMD_CS_LSB = 40;
  localparam int EXB_CMD_MODE_LSB = 42;
  localparam int EXB_CMD_WRITE_BIT = 44;
  localparam int EXB_CMD_RDY_BIT = 45;
  localparam int EXB_CMD_CNT_LSB = 46;
  localparam int EXB_CMD_W = 50;
  // Boot word fields
  localparam int EXB_BOOT_DIR_POL_BIT = 0;
  localparam int EXB_BOOT_LAST_POL_BIT = 1;
  localparam logic [31:0] EXB_BOOT_RESET = 32'h0000_0000;
  localparam logic EXB_CLK_RESET = 1'h1;
endpackage
`default_nettype wire

// >>> hdl/exb_fifo.sv
// Dual-clock word FIFO with gray-coded pointer crossing
`default_nettype none
module exb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_check
    $error("exb_fifo: DEPTH must be a power of two of at least 4");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_bin;
  logic [AW:0] rd_bin;
  logic [AW:0] wr_gray;
  logic [AW:0] rd_gray;
  logic [AW:0] rg_s1;
  logic [AW:0] rg_s2;
  logic [AW:0] wg_s1;
  logic [AW:0] wg_s2;
  logic [AW:0] next_wr_bin;
  logic [AW:0] next_rd_bin;

  assign next_wr_bin = wr_bin + (AW+1)'(1);
  assign next_rd_bin = rd_bin + (AW+1)'(1);
  // Full when the write pointer is one lap ahead of the read pointer
  // Nothing is accepted while the write side is held in reset
  assign wr_ready = wr_rst_n && (wr_gray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
  assign rd_valid = (rd_gray != wg_s2);
  assign rd_data = mem[rd_bin[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wr_bin[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wr_bin <= '0;
      wr_gray <= '0;
    end else if (wr_valid && wr_ready) begin
      wr_bin <= next_wr_bin;
      wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rd_bin <= '0;
      rd_gray <= '0;
    end else if (rd_valid && rd_ready) begin
      rd_bin <= next_rd_bin;
      rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      rg_s1 <= rd_gray;
      rg_s2 <= rg_s1;
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      wg_s1 <= '0;
      wg_s2 <= '0;
    end else begin
      wg_s1 <= wr_gray;
      wg_s2 <= wg_s1;
    end
  end
endmodule // exb_fifo
`default_nettype wire

// >>> hdl/exb_pins.sv
// Expansion bus pin engine: mode-dependent pin meaning, reset states, boot sampling
`default_nettype none
// What this block does
// (R1) Synchronous FIFO mode only in chip-select three
// (R2) FIFO access: shared pins carry word address
// (R3) FIFO access: shared pin is active-low write strobe
// (R4) Peripheral access: shared pins carry word address
// (R5) Peripheral access: shared pin is write strobe
// (R6) Peripheral access: active-high ready ends strobe
// (R7) Device-master host access: shared pins carry byte enables
// (R8) Host-port ready active low, direction by master
// (R9) Direction polarity latched at boot until reset
// (R10) External host burst-last uses boot polarity
// (R11) Device master drives burst-last active low
// (R12) Device master: shared pin is wait output
// (R13) In reset: clock high, control pins released
// (R14) Data pins sampled as boot configuration
// (R15) Back-off request aborts device-master access
// (R16) Peripheral access: without ready, strobe ends after programmed count
// (R17) Pin meaning follows the active access mode
module exb_pins #(
  parameter int DATA_W = exb_pkg::EXB_DATA_W,
  parameter int FIFO_DEPTH = exb_pkg::EXB_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic req_valid,
  output logic req_ready,
  input wire exb_pkg::exb_mode_type req_mode,
  input wire logic req_write,
  input wire logic [1:0] req_cs,
  input wire logic [3:0] req_addr,
  input wire logic [3:0] req_be,
  input wire logic req_use_ready,
  input wire logic [3:0] req_cycles,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_abort,
  output logic rsp_error,
  output logic [DATA_W-1:0] boot_config,
  output logic exp_output_clock,
  output logic exp_ctrl_oe_n,
  output logic [3:0] exp_chip_select,
  output logic [3:0] pin_be_addr,
  output logic pin_be_addr_oe_n,
  output logic exp_read_strobe,
  output logic exp_output_enable,
  output logic exp_addr_strobe,
  output logic pin_write_wait,
  output logic exp_bus_request,
  input wire logic exp_backoff_req,
  input wire logic exp_ready_line_in,
  output logic exp_ready_line_out,
  output logic exp_ready_line_oe_n,
  input wire logic exp_direction_line_in,
  output logic exp_direction_line_out,
  output logic exp_direction_line_oe_n,
  input wire logic exp_burst_last_in,
  output logic exp_burst_last_out,
  output logic exp_burst_last_oe_n,
  input wire logic [DATA_W-1:0] exp_data_bus_in,
  output logic [DATA_W-1:0] exp_data_bus_out,
  output logic exp_data_bus_oe_n
);
  if (DATA_W != exb_pkg::EXB_DATA_W || FIFO_DEPTH < 4) begin : g_check
    $error("exb_pins: DATA_W must be 32 and FIFO_DEPTH at least 4");
  end

  typedef enum logic [1:0] {st_idle, st_setup, st_strobe, st_hold} exb_state_type;

  exb_state_type state;
  logic sys_rs1;
  logic sys_rst_n;
  logic link_rs1;
  logic link_rst_n;
  logic [exb_pkg::EXB_CMD_W-1:0] q_data;
  logic q_valid;
  logic q_ready;
  logic [exb_pkg::EXB_CMD_W-1:0] cmd;
  logic [3:0] cnt;
  logic [DATA_W-1:0] rdata;
  logic abort;
  logic err;
  logic done_tgl;
  logic ack_tgl;
  logic dn_s1;
  logic dn_s2;
  logic ack_s1;
  logic ack_s2;
  logic rdy_s1;
  logic rdy_s2;
  logic dir_s1;
  logic dir_s2;
  logic last_s1;
  logic last_s2;
  logic boff_s1;
  logic boff_s2;
  logic [DATA_W-1:0] data_s1;
  logic [DATA_W-1:0] data_s2;
  logic [DATA_W-1:0] boot_cfg;
  logic boot_taken;
  logic clk_div;
  exb_pkg::exb_mode_type c_mode;
  exb_pkg::exb_mode_type q_mode;
  logic c_write;
  logic c_use_rdy;
  logic [1:0] c_cs;
  logic [3:0] exp_word_addr;
  logic [3:0] exp_byte_enable;
  logic exp_write_strobe;
  logic exp_wait_out;
  logic act;
  logic strb;
  logic plain;
  logic is_fifo;
  logic is_async;
  logic is_dev;
  logic is_ext;
  logic wr_level;
  logic host_wr;
  logic last_act;
  logic boff_hit;
  logic strobe_end;
  logic take_data;

  // Reset release, one synchroniser per clock domain
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_rs1 <= 1'b0;
      sys_rst_n <= 1'b0;
    end else begin
      sys_rs1 <= 1'b1;
      sys_rst_n <= sys_rs1;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_rs1 <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      link_rs1 <= 1'b1;
      link_rst_n <= link_rs1;
    end
  end

  // Access words cross into the link domain through the FIFO
  exb_fifo #(
    .WIDTH(exb_pkg::EXB_CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .wr_clk(sys_clk),
    .wr_rst_n(sys_rst_n),
    .wr_valid(req_valid),
    .wr_ready(req_ready),
    .wr_data({req_cycles, req_use_ready, req_write, req_mode, req_cs, req_be,
              req_addr, req_wdata}),
    .rd_clk(link_clk),
    .rd_rst_n(link_rst_n),
    .rd_valid(q_valid),
    .rd_ready(q_ready),
    .rd_data(q_data)
  );

  // Pin inputs, two stages before use; kept unreset so reset-time levels survive
  always_ff @(posedge link_clk) begin
    rdy_s1 <= exp_ready_line_in;
    rdy_s2 <= rdy_s1;
    dir_s1 <= exp_direction_line_in;
    dir_s2 <= dir_s1;
    last_s1 <= exp_burst_last_in;
    last_s2 <= last_s1;
    boff_s1 <= exp_backoff_req;
    boff_s2 <= boff_s1;
    data_s1 <= exp_data_bus_in;
    data_s2 <= data_s1;
  end

  // Configuration seen on the data pins during reset, taken once after release
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      boot_cfg <= exb_pkg::EXB_BOOT_RESET;
      boot_taken <= 1'b0;
    end else if (!boot_taken) begin
      boot_cfg <= data_s2; // [R14] [R9]
      boot_taken <= 1'b1;
    end
  end
  assign boot_config = boot_cfg;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      clk_div <= exb_pkg::EXB_CLK_RESET; // [R13]
    end else begin
      clk_div <= ~clk_div;
    end
  end
  assign exp_output_clock = clk_div;

  assign c_mode = exb_pkg::exb_mode_type'(cmd[exb_pkg::EXB_CMD_MODE_LSB +: 2]);
  assign q_mode = exb_pkg::exb_mode_type'(q_data[exb_pkg::EXB_CMD_MODE_LSB +: 2]);
  assign c_write = cmd[exb_pkg::EXB_CMD_WRITE_BIT];
  assign c_use_rdy = cmd[exb_pkg::EXB_CMD_RDY_BIT];
  assign c_cs = cmd[exb_pkg::EXB_CMD_CS_LSB +: 2];
  assign exp_word_addr = cmd[exb_pkg::EXB_CMD_ADDR_LSB +: 4];
  assign exp_byte_enable = cmd[exb_pkg::EXB_CMD_BE_LSB +: 4];
  assign is_fifo = (c_mode == exb_pkg::exb_mode_fifo);
  assign is_async = (c_mode == exb_pkg::exb_mode_async);
  assign is_dev = (c_mode == exb_pkg::exb_mode_host_dev);
  assign is_ext = (c_mode == exb_pkg::exb_mode_host_ext);
  assign plain = is_fifo || is_async;
  // A refused FIFO access keeps every strobe and select inactive and the mode pins released while it reports
  assign act = link_rst_n && (state != st_idle) && !err; // [R1]
  assign strb = link_rst_n && (state == st_strobe);
  assign wr_level = ~boot_cfg[exb_pkg::EXB_BOOT_DIR_POL_BIT]; // [R9]
  assign host_wr = (dir_s2 == wr_level); // [R9]
  assign last_act = (last_s2 == boot_cfg[exb_pkg::EXB_BOOT_LAST_POL_BIT]); // [R10]
  assign boff_hit = is_dev && boff_s2;
  assign q_ready = (state == st_idle) && boot_taken;

  always_comb begin
    strobe_end = 1'b0;
    if (state == st_strobe) begin
      case (c_mode)
        exb_pkg::exb_mode_fifo: strobe_end = 1'b1;
        exb_pkg::exb_mode_async: strobe_end = (cnt == 4'h0) && (!c_use_rdy || rdy_s2); // [R6] [R16]
        exb_pkg::exb_mode_host_dev: strobe_end = boff_s2 || !rdy_s2; // [R8] [R15]
        exb_pkg::exb_mode_host_ext: strobe_end = last_act; // [R10]
        default: strobe_end = 1'b1;
      endcase
    end
  end

  assign take_data = (state == st_strobe) &&
                     (is_ext ? host_wr : (!c_write && strobe_end && !boff_hit));

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state <= st_idle;
      cmd <= '0;
      cnt <= 4'h0;
      rdata <= '0;
      abort <= 1'b0;
      err <= 1'b0;
      done_tgl <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (q_valid && q_ready) begin
            cmd <= q_data;
            cnt <= q_data[exb_pkg::EXB_CMD_CNT_LSB +: 4];
            abort <= 1'b0;
            if (q_mode == exb_pkg::exb_mode_fifo &&
                q_data[exb_pkg::EXB_CMD_CS_LSB +: 2] != exb_pkg::EXB_FIFO_CS) begin
              err <= 1'b1; // [R1]
              done_tgl <= ~done_tgl;
              state <= st_hold;
            end else begin
              err <= 1'b0;
              state <= st_setup;
            end
          end
        end
        st_setup: state <= st_strobe;
        st_strobe: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1; // [R16]
          end
          if (take_data) begin
            rdata <= data_s2;
          end
          if (strobe_end) begin
            abort <= boff_hit; // [R15]
            done_tgl <= ~done_tgl;
            state <= st_hold;
          end
        end
        st_hold: begin
          if (ack_s2 == done_tgl) begin
            state <= st_idle; // [R17]
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // Completion handshake: done toggles out, acknowledge toggles back
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      dn_s1 <= 1'b0;
      dn_s2 <= 1'b0;
    end else begin
      dn_s1 <= done_tgl;
      dn_s2 <= dn_s1;
    end
  end

  // Result words are stable while the link side waits for the acknowledge
  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ack_tgl <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_abort <= 1'b0;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= (dn_s2 != ack_tgl);
      if (dn_s2 != ack_tgl) begin
        ack_tgl <= dn_s2;
        rsp_rdata <= rdata;
        rsp_abort <= abort;
        rsp_error <= err;
      end
    end
  end

  // Pin drive; every enable released and the clock held high while the link domain is in reset
  assign exp_ctrl_oe_n = ~link_rst_n; // [R13]
  assign exp_chip_select = ~((act && plain) ? (4'h1 << c_cs) : 4'h0);
  assign pin_be_addr = plain ? exp_word_addr : exp_byte_enable; // [R2] [R4] [R7]
  assign pin_be_addr_oe_n = ~(act && !is_ext); // [R17]
  assign exp_read_strobe = ~(strb && plain && !c_write);
  assign exp_output_enable = ~(act && plain && !c_write);
  assign exp_addr_strobe = ~(act && is_dev && state == st_setup);
  assign exp_write_strobe = ~(strb && plain && c_write); // [R3] [R5]
  assign exp_wait_out = (state == st_setup); // [R12]
  assign pin_write_wait = (act && is_dev) ? exp_wait_out : exp_write_strobe; // [R17]
  assign exp_bus_request = act && is_dev;
  assign exp_ready_line_out = ~(strb && is_ext); // [R8]
  assign exp_ready_line_oe_n = ~(act && is_ext); // [R8]
  assign exp_direction_line_out = c_write ? wr_level : ~wr_level; // [R9]
  assign exp_direction_line_oe_n = ~(act && is_dev);
  assign exp_burst_last_out = ~(strb && is_dev); // [R11]
  assign exp_burst_last_oe_n = ~(act && is_dev);
  assign exp_data_bus_out = cmd[exb_pkg::EXB_CMD_DATA_LSB +: DATA_W];
  assign exp_data_bus_oe_n = ~(act && ((!is_ext && c_write) || (is_ext && !host_wr)));

  sequence s_boff_hit;
    state == st_strobe && is_dev && boff_s2;
  endsequence
  sequence s_aborted;
    state == st_hold && abort ##1 exp_burst_last_out;
  endsequence

  a_fifo_cs_only: assert property ( // [R1]
    @(posedge link_clk) disable iff (!link_rst_n)
    (state == st_setup && is_fifo) |-> c_cs == exb_pkg::EXB_FIFO_CS)
    else $error("FIFO access outside chip-select three");
  a_fifo_addr_pins: assert property ( // [R2]
    @(posedge link_clk) disable iff (!link_rst_n)
    (strb && is_fifo) |-> (pin_be_addr == exp_word_addr && !pin_be_addr_oe_n))
    else $error("FIFO access without word address on shared pins");
  a_fifo_write_pulse: assert property ( // [R3]
    @(posedge link_clk) disable iff (!link_rst_n)
    (strb && is_fifo && c_write) |-> !pin_write_wait ##1 (pin_write_wait && state == st_hold))
    else $error("FIFO write strobe not a single low cycle");
  a_async_addr_pins: assert property ( // [R4]
    @(posedge link_clk) disable iff (!link_rst_n)
    (act && is_async) |-> (pin_be_addr == exp_word_addr && !pin_be_addr_oe_n))
    else $error("Peripheral access without word address");
  a_async_write_low: assert property ( // [R5]
    @(posedge link_clk) disable iff (!link_rst_n)
    (strb && is_async && c_write) |-> (!pin_write_wait && exp_read_strobe))
    else $error("Peripheral write strobe not driven low");
  a_async_ready_wait: assert property ( // [R6]
    @(posedge link_clk) disable iff (!link_rst_n)
    (strb && is_async && c_use_rdy && cnt == 4'h0 && !rdy_s2) |=> state == st_strobe)
    else $error("Strobe ended without ready");
  a_host_byte_en: assert property ( // [R7]
    @(posedge link_clk) disable iff (!link_rst_n)
    (act && is_dev) |-> (pin_be_addr == exp_byte_enable && !pin_be_addr_oe_n))
    else $error("Host-port access without byte enables");
  a_ready_direction: assert property ( // [R8]
    @(posedge link_clk) disable iff (!link_rst_n)
    act |-> (exp_ready_line_oe_n == !is_ext))
    else $error("Ready line driven in wrong direction");
  a_dir_polarity: assert property ( // [R9]
    @(posedge link_clk) disable iff (!link_rst_n)
    (act && is_dev) |->
      exp_direction_line_out == (c_write ^ boot_cfg[exb_pkg::EXB_BOOT_DIR_POL_BIT]))
    else $error("Direction polarity differs from boot setting");
  a_ext_last_end: assert property ( // [R10]
    @(posedge link_clk) disable iff (!link_rst_n)
    (strb && is_ext && last_act) |=> (state == st_hold && exp_ready_line_out))
    else $error("External burst did not end on last");
  a_dev_last_low: assert property ( // [R11]
    @(posedge link_clk) disable iff (!link_rst_n)
    (state == st_setup && is_dev) |-> exp_burst_last_out ##1 !exp_burst_last_out)
    else $error("Burst-last not active low in strobe");
  a_dev_wait_out: assert property ( // [R12]
    @(posedge link_clk) disable iff (!link_rst_n)
    (act && is_dev) |-> pin_write_wait == (state == st_setup))
    else $error("Wait output wrong while device masters");
  a_reset_pins: assert property ( // [R13]
    @(posedge sys_clk) !reset_n |->
      (exp_output_clock && exp_ctrl_oe_n && exp_data_bus_oe_n && pin_be_addr_oe_n))
    else $error("Pins not released during reset");
  a_boot_sample: assert property ( // [R14]
    @(posedge link_clk) disable iff (!link_rst_n)
    $rose(boot_taken) |-> boot_cfg == $past(data_s2))
    else $error("Boot word not taken from data pins");
  a_backoff_abort: assert property ( // [R15]
    @(posedge link_clk) disable iff (!link_rst_n)
    s_boff_hit |=> s_aborted)
    else $error("Back-off did not abort access");
  a_async_count: assert property ( // [R16]
    @(posedge link_clk) disable iff (!link_rst_n)
    (strb && is_async && !c_use_rdy && cnt == 4'h0) |=> state == st_hold)
    else $error("Strobe overran programmed count");
  a_idle_release: assert property ( // [R17]
    @(posedge link_clk) disable iff (!link_rst_n)
    (state == st_idle) |-> (pin_be_addr_oe_n && exp_ready_line_oe_n &&
      exp_direction_line_oe_n && exp_burst_last_oe_n && exp_data_bus_oe_n))
    else $error("Mode pins driven with no access");
endmodule // exb_pins
`default_nettype wire

// >>> sim/exb_far_end.sv
// Far-side model: peripheral, FIFO, host and boot strap driver
`default_nettype none
module exb_far_end (
  input wire logic link_clk,
  input wire exb_pkg::exb_mode_type req_mode,
  input wire logic [7:0] delay,
  input wire logic backoff_en,
  input wire logic boot_phase,
  input wire logic [31:0] boot_word,
  input wire logic [31:0] rdata,
  input wire logic [3:0] exp_chip_select,
  input wire logic exp_bus_request,
  input wire logic exp_ready_line_oe_n,
  input wire logic exp_data_bus_oe_n,
  output logic exp_ready_line_in,
  output logic exp_burst_last_in,
  output logic exp_backoff_req,
  output logic [31:0] exp_data_bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  logic active;
  logic late;
  assign active = (exp_chip_select != 4'hf) || exp_bus_request || !exp_ready_line_oe_n;
  assign late = active && (cnt >= delay);
  always @(posedge link_clk) cnt <= active ? cnt + 8'h01 : 8'h00;
  // Outside boot and accesses the bus shows a changing pattern, never the last value; a released bus during an access shows rdata
  always @(posedge link_clk) begin
    if (boot_phase) exp_data_bus_in <= boot_word;
    else if (active && exp_data_bus_oe_n) exp_data_bus_in <= rdata;
    else exp_data_bus_in <= ~exp_data_bus_in;
  end
  assign exp_ready_line_in = (req_mode == exb_pkg::exb_mode_host_dev) ? !late : late;
  assign exp_burst_last_in = late ? boot_word[1] : !boot_word[1];
  assign exp_backoff_req = backoff_en && exp_bus_request && cnt >= 8'h02;
endmodule // exb_far_end
`default_nettype wire

// >>> sim/exb_pins_bench.sv
// Self-checking bench for the expansion bus pin engine
`default_nettype none
module exb_pins_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BOOT = 32'h0000_0003;
  logic sys_clk = 0, link_clk = 0, reset_n = 0, req_valid = 0, req_write = 0;
  logic req_use_ready = 0, backoff_en = 0, boot_phase = 1, exp_direction_line_in = 0;
  exb_pkg::exb_mode_type req_mode = exb_pkg::exb_mode_async;
  logic [1:0] req_cs = 2'h0;
  logic [3:0] req_addr = 4'h0, req_be = 4'h0, req_cycles = 4'h0;
  logic [31:0] req_wdata = 32'h0000_0000, rdata = 32'hc3c3_3c3c, boot_word = BOOT;
  logic [7:0] delay = 8'h04;
  logic req_ready, rsp_valid, rsp_abort, rsp_error, exp_output_clock, exp_ctrl_oe_n;
  logic pin_be_addr_oe_n, exp_read_strobe, exp_output_enable, exp_addr_strobe;
  logic pin_write_wait, exp_bus_request, exp_ready_line_out, exp_ready_line_oe_n;
  logic exp_direction_line_out, exp_direction_line_oe_n, exp_burst_last_out;
  logic exp_burst_last_oe_n, exp_data_bus_oe_n, exp_ready_line_in, exp_burst_last_in;
  logic exp_backoff_req;
  logic [31:0] rsp_rdata, boot_config, exp_data_bus_out, exp_data_bus_in;
  logic [3:0] exp_chip_select, pin_be_addr, cs_seen, pin_seen;
  logic dir_seen;
  int wr_low, rd_low, rdy_low, bl_low, wait_hi, cyc, n_mismatch, samples_checked;
  exb_pins dut (
    .sys_clk, .reset_n, .link_clk, .req_valid, .req_ready, .req_mode, .req_write,
    .req_cs, .req_addr, .req_be, .req_use_ready, .req_cycles, .req_wdata, .rsp_valid,
    .rsp_rdata, .rsp_abort, .rsp_error, .boot_config, .exp_output_clock, .exp_ctrl_oe_n,
    .exp_chip_select, .pin_be_addr, .pin_be_addr_oe_n, .exp_read_strobe,
    .exp_output_enable, .exp_addr_strobe, .pin_write_wait, .exp_bus_request,
    .exp_backoff_req, .exp_ready_line_in, .exp_ready_line_out, .exp_ready_line_oe_n,
    .exp_direction_line_in, .exp_direction_line_out, .exp_direction_line_oe_n,
    .exp_burst_last_in, .exp_burst_last_out, .exp_burst_last_oe_n, .exp_data_bus_in,
    .exp_data_bus_out, .exp_data_bus_oe_n
  );
  exb_far_end far (
    .link_clk, .req_mode, .delay, .backoff_en, .boot_phase, .boot_word, .rdata,
    .exp_chip_select, .exp_bus_request, .exp_ready_line_oe_n, .exp_data_bus_oe_n,
    .exp_ready_line_in, .exp_burst_last_in, .exp_backoff_req, .exp_data_bus_in
  );
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end
  // Pin monitor in the link domain
  always @(posedge link_clk) begin
    if (!pin_write_wait && !exp_ctrl_oe_n) wr_low++;
    if (!exp_read_strobe && !exp_ctrl_oe_n) rd_low++;
    if (!exp_ready_line_oe_n && !exp_ready_line_out) rdy_low++;
    if (!exp_burst_last_oe_n && !exp_burst_last_out) bl_low++;
    if (pin_write_wait && !exp_addr_strobe && !exp_ctrl_oe_n) wait_hi++;
    if (exp_chip_select != 4'hf) cs_seen = exp_chip_select;
    if (!pin_be_addr_oe_n) pin_seen = pin_be_addr;
    if (!exp_direction_line_oe_n) dir_seen = exp_direction_line_out;
  end
  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input exb_pkg::exb_mode_type m, input logic w, input logic [1:0] cs,
      input logic [3:0] a, input logic [3:0] c, input logic rdy);
    int n;
    repeat (6) @(negedge sys_clk);
    wr_low = 0; rd_low = 0; rdy_low = 0; bl_low = 0; wait_hi = 0;
    cs_seen = 4'hf; pin_seen = 4'h0; dir_seen = 1'bx;
    req_mode = m; req_write = w; req_cs = cs; req_addr = a; req_be = ~a;
    req_cycles = c; req_use_ready = rdy; req_wdata = {8{a}}; req_valid = 1;
    n = 0;
    while (!req_ready && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 800) begin
      @(negedge sys_clk);
      n++;
    end
    chk("rsp_valid", 1, rsp_valid);
  endtask
  task automatic t_reset();
    repeat (4) @(negedge sys_clk);
    chk("clock_in_reset", 1, exp_output_clock);
    chk("ctrl_oe_n", 1, exp_ctrl_oe_n);
    chk("be_addr_oe_n", 1, pin_be_addr_oe_n);
    reset_n = 1;
    repeat (6) @(negedge sys_clk);
    boot_phase = 0;
    chk("boot_config", BOOT, boot_config);
  endtask
  task automatic t_plain();
    run(exb_pkg::exb_mode_async, 1, 2'h2, 4'h5, 4'h1, 0);
    chk("async_wr_strobe", 2, wr_low);
    chk("async_addr", 4'h5, pin_seen);
    chk("async_cs", 4'hb, cs_seen);
    delay = 8'h06;
    rdata = 32'ha5a5_5a5a;
    run(exb_pkg::exb_mode_async, 0, 2'h1, 4'h9, 4'h0, 1);
    chk("rdy_rdata", rdata, rsp_rdata);
    chk("rdy_stretch", 1, rd_low > 4);
    run(exb_pkg::exb_mode_fifo, 1, 2'h3, 4'h3, 4'h0, 0);
    chk("fifo_strobe", 1, wr_low);
    chk("fifo_addr", 4'h3, pin_seen);
    chk("fifo_cs", 4'h7, cs_seen);
    chk("fifo_err", 0, rsp_error);
    run(exb_pkg::exb_mode_fifo, 0, 2'h1, 4'h3, 4'h0, 0);
    chk("fifo_bad_err", 1, rsp_error);
    chk("fifo_bad_cs", 4'hf, cs_seen);
  endtask
  task automatic t_host();
    delay = 8'h04;
    run(exb_pkg::exb_mode_host_dev, 1, 2'h0, 4'h6, 4'h0, 0);
    chk("host_be", 4'h9, pin_seen);
    chk("host_last", 1, bl_low > 0);
    chk("host_wait", 1, wait_hi > 0);
    chk("host_dir_wr", !BOOT[0], dir_seen);
    chk("host_abort", 0, rsp_abort);
    backoff_en = 1;
    run(exb_pkg::exb_mode_host_dev, 0, 2'h0, 4'ha, 4'h0, 0);
    chk("backoff_abort", 1, rsp_abort);
    chk("host_dir_rd", BOOT[0], dir_seen);
    backoff_en = 0;
    run(exb_pkg::exb_mode_async, 0, 2'h2, 4'hc, 4'h0, 0);
    chk("remap_addr", 4'hc, pin_seen);
    chk("remap_strobe", 1, rd_low);
    delay = 8'h06;
    rdata = 32'h1234_5678;
    exp_direction_line_in = ~BOOT[0];
    run(exb_pkg::exb_mode_host_ext, 0, 2'h0, 4'h1, 4'h0, 0);
    chk("ext_rdy_low", 1, rdy_low > 3);
    chk("ext_data", rdata, rsp_rdata);
  endtask
  task automatic t_fill();
    int acc, got, n;
    delay = 8'h28;
    @(negedge sys_clk);
    req_mode = exb_pkg::exb_mode_async;
    req_use_ready = 1;
    req_write = 0;
    req_valid = 1;
    acc = 0;
    while (req_ready && acc < 40) begin
      acc++;
      @(negedge sys_clk);
    end
    req_valid = 0;
    chk("fill_refused", 1, req_ready === 1'b0 && acc >= 16);
    got = 0;
    n = 0;
    while (got < acc && n < 4000) begin
      @(negedge sys_clk);
      n++;
      if (rsp_valid === 1'b1) got++;
    end
    chk("drained", acc, got);
  endtask
  initial begin
    t_reset();
    t_plain();
    t_host();
    t_fill();
    end_sim();
  end
endmodule // exb_pins_bench
`default_nettype wire
